// File: src/tpb_ctrl.sv
// What the document requires of this block and of its host
// (RULE1) Power amp level field sets output power
// (RULE2) Host writes whole transmit control word
// (RULE3) Host drives regulator enable input
// (RULE4) Host resets before regulator off; reprograms
// (RULE5) Monitor runs only while enabled, regulator on
// (RULE6) Battery good high above toggle threshold
// (RULE7) Threshold is five-bit unsigned code
// (RULE8) Host waits 100 us before first result
// (RULE9) Host waits 2 us after threshold change
// (RULE10) Host sets bypass bit for external clock
// (RULE11) Supply switch low receive, high transmit
// (RULE12) Host resets, starts oscillator before tests
// (RULE13) Test modes 2/3 plus DAC word give carrier
// (RULE14) Mode 3 sends CRC low byte, feeds 0xff
// (RULE15) Pattern starts 0x00, 0x78, repeats 65535 bits
// (RULE16) Sync header precedes data in every mode
// (RULE17) Mode 2 loops 128-byte buffer, ignores underflow
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module tpb_ctrl #(
	parameter int BUF_DEPTH = 128
) (
	input  logic                          aclk,
	input  logic                          aresetn,
	input  logic [tpb_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  logic                          s_axi_awvalid,
	output logic                          s_axi_awready,
	input  logic [31:0]                   s_axi_wdata,
	input  logic [3:0]                    s_axi_wstrb,
	input  logic                          s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  logic                          s_axi_bready,
	input  logic [tpb_pkg::ADDR_W-1:0]    s_axi_araddr,
	input  logic                          s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  logic                          s_axi_rready,
	input  logic                          regulator_enable_input,
	input  logic                          battery_compare_in,
	output logic                          irq,
	output logic [tpb_pkg::PA_W-1:0]      power_amp_level_field,
	output logic                          battery_monitor_enable_bit,
	output logic [tpb_pkg::BATT_CODE_W-1:0] battery_threshold_code,
	output logic                          oscillator_bypass_bit,
	output logic                          oscillator_enable,
	output logic                          trx_supply_switch_output,
	output logic                          dac_override,
	output logic [15:0]                   dac_static_value,
	output logic [7:0]                    tx_byte,
	output logic                          tx_byte_valid
);
	localparam int PTR_W = $clog2(BUF_DEPTH);
	localparam int CNT_W = $clog2(BUF_DEPTH + 1);
	localparam int DIV_W = $clog2(tpb_pkg::BYTE_CYCLES);

	logic [15:0] main_r, tx_cfg_r, modem_cfg_r, dac_test_r;
	logic [6:0]  batt_cfg_r;
	logic [tpb_pkg::IRQ_W-1:0] status_r, mask_r, irq_ev;
	logic [1:0]  reg_sync_r, cmp_sync_r;
	logic        cfg_rst, batt_good_r, osc_on_r;
	logic        aw_held_r, w_held_r, wr_do;
	logic [tpb_pkg::ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r, rd_val;
	logic [3:0]  wstrb_r;
	logic        stb_osc, stb_txon, stb_txoff, buf_push;
	tpb_pkg::tpb_tx_state_t tx_state_r;
	logic [2:0]  sync_idx_r;
	logic [DIV_W-1:0] div_r;
	logic        byte_tick, underflow, pop;
	logic [15:0] crc_r;
	logic [7:0]  mem [BUF_DEPTH];
	logic [PTR_W-1:0] wr_ptr_r, rd_ptr_r;
	logic [CNT_W-1:0] count_r;
	logic [1:0]  mode;
	logic [7:0]  data_byte;

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ tpb_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic mapped(input logic [tpb_pkg::ADDR_W-1:0] a);
		return a == tpb_pkg::OFF_MAIN || a == tpb_pkg::OFF_TX_CFG || a == tpb_pkg::OFF_MODEM_CFG ||
			a == tpb_pkg::OFF_DAC_TEST || a == tpb_pkg::OFF_BATT_CFG || a == tpb_pkg::OFF_STROBE ||
			a == tpb_pkg::OFF_TXBUF || a == tpb_pkg::OFF_IRQ_STATUS || a == tpb_pkg::OFF_IRQ_MASK ||
			a == tpb_pkg::OFF_STATE;
	endfunction

	// Pins from outside the clock domain
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			reg_sync_r <= 2'h0;
			cmp_sync_r <= 2'h0;
		end
		else
		begin
			reg_sync_r <= {reg_sync_r[0], regulator_enable_input};
			cmp_sync_r <= {cmp_sync_r[0], battery_compare_in};
		end
	end

	// Regulator off means configuration is lost, as a reset would
	assign cfg_rst = !aresetn || !reg_sync_r[1]; // see (RULE4)
	assign mode    = modem_cfg_r[tpb_pkg::MODE_LSB +: tpb_pkg::MODE_W];

	// AXI write channels; one write outstanding, readies drop until B taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r     <= 1'b0;
			w_held_r      <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= tpb_pkg::RESP_OKAY;
			awaddr_r      <= '0;
			wdata_r       <= 32'h0;
			wstrb_r       <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r     <= 1'b1;
				awaddr_r      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r     <= 1'b1;
				wdata_r      <= s_axi_wdata;
				wstrb_r      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_do)
			begin
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(awaddr_r) ? tpb_pkg::RESP_OKAY : tpb_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	assign wr_do     = aw_held_r && w_held_r && !s_axi_bvalid;
	assign stb_osc   = wr_do && awaddr_r == tpb_pkg::OFF_STROBE && wdata_r[tpb_pkg::STB_OSC_BIT] && wstrb_r[0];
	assign stb_txon  = wr_do && awaddr_r == tpb_pkg::OFF_STROBE && wdata_r[tpb_pkg::STB_TXON_BIT] && wstrb_r[0];
	assign stb_txoff = wr_do && awaddr_r == tpb_pkg::OFF_STROBE && wdata_r[tpb_pkg::STB_TXOFF_BIT] && wstrb_r[0];
	assign buf_push  = wr_do && awaddr_r == tpb_pkg::OFF_TXBUF && wstrb_r[0];

	// Configuration registers
	always_ff @(posedge aclk)
	begin
		if (cfg_rst)
		begin
			main_r     <= 16'h0;
			tx_cfg_r    <= tpb_pkg::TX_CFG_RESET;
			modem_cfg_r <= tpb_pkg::MODEM_CFG_RESET;
			dac_test_r  <= tpb_pkg::DAC_TEST_RESET;
			batt_cfg_r  <= 7'h0;
			mask_r      <= '0;
		end
		else if (wr_do)
		begin
			unique case (awaddr_r)
				tpb_pkg::OFF_MAIN:      main_r      <= merge16(main_r, wdata_r, wstrb_r);
				tpb_pkg::OFF_TX_CFG:    tx_cfg_r    <= merge16(tx_cfg_r, wdata_r, wstrb_r);
				tpb_pkg::OFF_MODEM_CFG: modem_cfg_r <= merge16(modem_cfg_r, wdata_r, wstrb_r);
				tpb_pkg::OFF_DAC_TEST:  dac_test_r  <= merge16(dac_test_r, wdata_r, wstrb_r);
				tpb_pkg::OFF_BATT_CFG:  if (wstrb_r[0]) batt_cfg_r <= {1'b0, wdata_r[5:0]};
				tpb_pkg::OFF_IRQ_MASK: if (wstrb_r[0]) mask_r <= wdata_r[tpb_pkg::IRQ_W-1:0];
				default:               ;
			endcase
		end
	end

	// Battery monitor: status only while enabled with regulator up
	always_ff @(posedge aclk)
	begin
		if (cfg_rst)
			batt_good_r <= 1'b0;
		else
			batt_good_r <= batt_cfg_r[tpb_pkg::BATT_EN_BIT] && cmp_sync_r[1]; // see (RULE5) see (RULE6)
	end

	// Outputs to the analog and RF side
	always_ff @(posedge aclk)
	begin
		if (cfg_rst)
		begin
			power_amp_level_field      <= '0;
			battery_monitor_enable_bit <= 1'b0;
			battery_threshold_code     <= '0;
			oscillator_bypass_bit      <= 1'b0;
			trx_supply_switch_output   <= 1'b0;
			dac_override               <= 1'b0;
			dac_static_value           <= 16'h0;
		end
		else
		begin
			power_amp_level_field      <= tx_cfg_r[tpb_pkg::PA_LSB +: tpb_pkg::PA_W]; // see (RULE1)
			battery_monitor_enable_bit <= batt_cfg_r[tpb_pkg::BATT_EN_BIT]; // see (RULE5)
			battery_threshold_code     <= batt_cfg_r[tpb_pkg::BATT_CODE_LSB +: tpb_pkg::BATT_CODE_W]; // see (RULE7)
			oscillator_bypass_bit      <= main_r[tpb_pkg::BYPASS_BIT];
			trx_supply_switch_output   <= tx_state_r != tpb_pkg::TX_IDLE; // see (RULE11)
			dac_override               <= tx_state_r != tpb_pkg::TX_IDLE && mode[1] && dac_test_r != 16'h0; // see (RULE13)
			dac_static_value           <= dac_test_r;
		end
	end

	// Oscillator; transmit is refused until it has been started
	always_ff @(posedge aclk)
	begin
		if (cfg_rst)
			osc_on_r <= 1'b0;
		else if (stb_osc)
			osc_on_r <= 1'b1;
	end
	assign oscillator_enable = osc_on_r;

	// Byte pacing at 250 kbit/s
	always_ff @(posedge aclk)
	begin
		if (cfg_rst || tx_state_r == tpb_pkg::TX_IDLE || byte_tick)
			div_r <= '0;
		else
			div_r <= div_r + 1'b1;
	end
	assign byte_tick = div_r == DIV_W'(tpb_pkg::BYTE_CYCLES - 1);

	assign pop       = tx_state_r == tpb_pkg::TX_DATA && byte_tick && !mode[1];
	assign underflow = pop && count_r == '0;
	assign data_byte = mode == tpb_pkg::MODE_PRBS ? crc_r[7:0] : mem[rd_ptr_r];

	always_ff @(posedge aclk)
	begin
		if (cfg_rst)
		begin
			tx_state_r <= tpb_pkg::TX_IDLE;
			sync_idx_r <= 3'h0;
		end
		else if (stb_txoff)
			tx_state_r <= tpb_pkg::TX_IDLE;
		else
		begin
			unique case (tx_state_r)
				tpb_pkg::TX_IDLE:
					if (stb_txon && osc_on_r)
					begin
						tx_state_r <= tpb_pkg::TX_SYNC; // see (RULE16)
						sync_idx_r <= 3'h0;
					end
				tpb_pkg::TX_SYNC:
					if (byte_tick)
					begin
						if (sync_idx_r == 3'(tpb_pkg::PREAMBLE_BYTES))
							tx_state_r <= tpb_pkg::TX_DATA;
						else
							sync_idx_r <= sync_idx_r + 3'h1;
					end
				tpb_pkg::TX_DATA:
					if (underflow)
						tx_state_r <= tpb_pkg::TX_IDLE; // Loop mode never gets here, see (RULE17)
			endcase
		end
	end

	// Serialiser handoff: one byte per tick
	always_ff @(posedge aclk)
	begin
		if (cfg_rst)
		begin
			tx_byte       <= 8'h0;
			tx_byte_valid <= 1'b0;
		end
		else
		begin
			tx_byte_valid <= 1'b0;
			if (byte_tick && tx_state_r == tpb_pkg::TX_SYNC)
			begin
				tx_byte_valid <= 1'b1;
				tx_byte       <= sync_idx_r == 3'(tpb_pkg::PREAMBLE_BYTES) ? tpb_pkg::SFD_BYTE
					: tpb_pkg::PREAMBLE_BYTE; // see (RULE16)
			end
			else if (byte_tick && tx_state_r == tpb_pkg::TX_DATA && !underflow)
			begin
				tx_byte_valid <= 1'b1;
				tx_byte       <= data_byte; // see (RULE14)
			end
		end
	end

	// Pattern generator restarts from zero at each start
	always_ff @(posedge aclk)
	begin
		if (cfg_rst || tx_state_r != tpb_pkg::TX_DATA)
			crc_r <= tpb_pkg::CRC_INIT; // see (RULE15)
		else if (byte_tick && mode == tpb_pkg::MODE_PRBS)
			crc_r <= crc_byte(crc_r, tpb_pkg::PRBS_FEED); // see (RULE14)
	end

	// Transmit buffer; a push into a full buffer is dropped
	always_ff @(posedge aclk)
	begin
		if (buf_push && count_r != CNT_W'(BUF_DEPTH))
			mem[wr_ptr_r] <= wdata_r[7:0];
	end

	always_ff @(posedge aclk)
	begin
		if (cfg_rst)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			if (buf_push && count_r != CNT_W'(BUF_DEPTH))
				wr_ptr_r <= PTR_W'((wr_ptr_r == PTR_W'(BUF_DEPTH - 1)) ? 0 : wr_ptr_r + 1'b1);
			if (tx_state_r == tpb_pkg::TX_IDLE && stb_txon && mode == tpb_pkg::MODE_LOOP)
				rd_ptr_r <= '0;
			else if (tx_state_r == tpb_pkg::TX_DATA && byte_tick && mode != tpb_pkg::MODE_PRBS && !underflow)
				rd_ptr_r <= PTR_W'((rd_ptr_r == PTR_W'(BUF_DEPTH - 1)) ? 0 : rd_ptr_r + 1'b1); // see (RULE17)
			if ((buf_push && count_r != CNT_W'(BUF_DEPTH)) && !(pop && !underflow))
				count_r <= count_r + 1'b1;
			else if (!(buf_push && count_r != CNT_W'(BUF_DEPTH)) && pop && !underflow)
				count_r <= count_r - 1'b1;
		end
	end

	// Interrupts: a new event wins over a same-cycle clear
	assign irq_ev[tpb_pkg::IRQ_BATT_LOW]  = batt_good_r && !(batt_cfg_r[tpb_pkg::BATT_EN_BIT] && cmp_sync_r[1])
		&& batt_cfg_r[tpb_pkg::BATT_EN_BIT];
	assign irq_ev[tpb_pkg::IRQ_UNDERFLOW] = underflow;
	assign irq_ev[tpb_pkg::IRQ_TX_START]  = tx_state_r == tpb_pkg::TX_IDLE && stb_txon && osc_on_r && !stb_txoff;

	always_ff @(posedge aclk)
	begin
		if (cfg_rst)
		begin
			status_r <= '0;
			irq      <= 1'b0;
		end
		else
		begin
			status_r <= (status_r & ~((wr_do && awaddr_r == tpb_pkg::OFF_IRQ_STATUS && wstrb_r[0])
				? wdata_r[tpb_pkg::IRQ_W-1:0] : '0)) | irq_ev;
			irq      <= |(status_r & mask_r);
		end
	end

	always_comb
	begin
		rd_val = 32'h0;
		unique case (s_axi_araddr)
			tpb_pkg::OFF_MAIN:       rd_val = {16'h0, main_r};
			tpb_pkg::OFF_TX_CFG:     rd_val = {16'h0, tx_cfg_r};
			tpb_pkg::OFF_MODEM_CFG:  rd_val = {16'h0, modem_cfg_r};
			tpb_pkg::OFF_DAC_TEST:   rd_val = {16'h0, dac_test_r};
			tpb_pkg::OFF_BATT_CFG:   rd_val = {25'h0, batt_good_r, batt_cfg_r[5:0]}; // see (RULE6)
			tpb_pkg::OFF_IRQ_STATUS: rd_val = {29'h0, status_r};
			tpb_pkg::OFF_IRQ_MASK:   rd_val = {29'h0, mask_r};
			tpb_pkg::OFF_STATE:      rd_val = {16'h0, 8'(count_r), 4'h0, tx_state_r, 1'b0, osc_on_r};
			default:                 rd_val = 32'h0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= tpb_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_val;
			s_axi_rresp   <= mapped(s_axi_araddr) ? tpb_pkg::RESP_OKAY : tpb_pkg::RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	property p_power_amp_level_field;
		@(posedge aclk) disable iff (cfg_rst)
		wr_do && awaddr_r == tpb_pkg::OFF_TX_CFG && wstrb_r[0] |-> ##2 power_amp_level_field == $past(wdata_r[4:0], 2);
	endproperty
	a_power_amp_level_field: assert property (p_power_amp_level_field) else $error("Power level not taken from write"); // see (RULE1)

	property p_batt_off;
		@(posedge aclk) disable iff (cfg_rst)
		!batt_cfg_r[tpb_pkg::BATT_EN_BIT] |=> !batt_good_r;
	endproperty
	a_batt_off: assert property (p_batt_off) else $error("Battery status high while disabled"); // see (RULE5)

	property p_batt_good;
		@(posedge aclk) disable iff (cfg_rst)
		batt_cfg_r[tpb_pkg::BATT_EN_BIT] ##1 batt_cfg_r[tpb_pkg::BATT_EN_BIT] |-> batt_good_r == $past(cmp_sync_r[1]);
	endproperty
	a_batt_good: assert property (p_batt_good) else $error("Battery status does not follow comparator"); // see (RULE6)

	property p_thresh;
		@(posedge aclk) disable iff (cfg_rst)
		wr_do && awaddr_r == tpb_pkg::OFF_BATT_CFG && wstrb_r[0] |-> ##2 battery_threshold_code == $past(wdata_r[4:0], 2);
	endproperty
	a_thresh: assert property (p_thresh) else $error("Threshold code not applied"); // see (RULE7)

	property p_switch;
		@(posedge aclk) disable iff (cfg_rst)
		tx_state_r != tpb_pkg::TX_IDLE ##1 tx_state_r != tpb_pkg::TX_IDLE |-> trx_supply_switch_output;
	endproperty
	a_switch: assert property (p_switch) else $error("Supply switch low while transmitting"); // see (RULE11)

	property p_carrier;
		@(posedge aclk) disable iff (cfg_rst)
		dac_override |-> $past(mode[1]) && $past(dac_test_r) != 16'h0 && $past(tx_state_r) != tpb_pkg::TX_IDLE;
	endproperty
	a_carrier: assert property (p_carrier) else $error("DAC override without test mode"); // see (RULE13)

	property p_prbs_byte;
		@(posedge aclk) disable iff (cfg_rst)
		tx_state_r == tpb_pkg::TX_DATA && byte_tick && mode == tpb_pkg::MODE_PRBS && !stb_txoff
		|=> tx_byte_valid && tx_byte == $past(crc_r[7:0]);
	endproperty
	a_prbs_byte: assert property (p_prbs_byte) else $error("Pattern byte is not CRC low byte"); // see (RULE14)

	property p_prbs_start;
		@(posedge aclk) disable iff (cfg_rst)
		$rose(tx_state_r == tpb_pkg::TX_DATA) |-> crc_r == tpb_pkg::CRC_INIT;
	endproperty
	a_prbs_start: assert property (p_prbs_start) else $error("Pattern does not start from zero"); // see (RULE15)

	property p_sync_first;
		@(posedge aclk) disable iff (cfg_rst)
		tx_state_r == tpb_pkg::TX_IDLE ##1 tx_state_r != tpb_pkg::TX_IDLE |-> tx_state_r == tpb_pkg::TX_SYNC;
	endproperty
	a_sync_first: assert property (p_sync_first) else $error("Data sent without sync header"); // see (RULE16)

	property p_loop;
		@(posedge aclk) disable iff (cfg_rst)
		tx_state_r == tpb_pkg::TX_DATA && mode == tpb_pkg::MODE_LOOP && !stb_txoff |=> tx_state_r == tpb_pkg::TX_DATA;
	endproperty
	a_loop: assert property (p_loop) else $error("Loop mode stopped on underflow"); // see (RULE17)
endmodule

// File: src/tpb_pkg.sv
package tpb_pkg;
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  OFF_MAIN        = 8'h00;
	localparam logic [7:0]  OFF_TX_CFG      = 8'h04;
	localparam logic [7:0]  OFF_MODEM_CFG   = 8'h08;
	localparam logic [7:0]  OFF_DAC_TEST    = 8'h0c;
	localparam logic [7:0]  OFF_BATT_CFG    = 8'h10;
	localparam logic [7:0]  OFF_STROBE      = 8'h14;
	localparam logic [7:0]  OFF_TXBUF       = 8'h18;
	localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h1c;
	localparam logic [7:0]  OFF_IRQ_MASK    = 8'h20;
	localparam logic [7:0]  OFF_STATE       = 8'h24;
	localparam logic [15:0] TX_CFG_RESET    = 16'ha0ff;
	localparam logic [15:0] MODEM_CFG_RESET = 16'h0000;
	localparam logic [15:0] DAC_TEST_RESET  = 16'h0000;
	localparam int          PA_LSB          = 0;
	localparam int          PA_W            = 5;
	localparam int          BYPASS_BIT      = 0;
	localparam int          MODE_LSB        = 2;
	localparam int          MODE_W          = 2;
	localparam logic [1:0]  MODE_LOOP       = 2'h2;
	localparam logic [1:0]  MODE_PRBS       = 2'h3;
	localparam int          BATT_CODE_LSB   = 0;
	localparam int          BATT_CODE_W     = 5;
	localparam int          BATT_EN_BIT     = 5;
	localparam int          BATT_OK_BIT     = 6;
	localparam int          STB_OSC_BIT     = 0;
	localparam int          STB_TXON_BIT    = 1;
	localparam int          STB_TXOFF_BIT   = 2;
	localparam int          IRQ_W           = 3;
	localparam int          IRQ_BATT_LOW    = 0;
	localparam int          IRQ_UNDERFLOW   = 1;
	localparam int          IRQ_TX_START    = 2;
	localparam int          CLK_PERIOD_NS   = 40;
	localparam int          BYTE_TIME_NS    = 32000;
	localparam int          BYTE_CYCLES     = (BYTE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          PREAMBLE_BYTES  = 4;
	localparam logic [7:0]  PREAMBLE_BYTE   = 8'h00;
	localparam logic [7:0]  SFD_BYTE        = 8'ha7;
	localparam logic [15:0] CRC_POLY        = 16'h8408;
	localparam logic [15:0] CRC_INIT        = 16'h0000;
	localparam logic [7:0]  PRBS_FEED       = 8'hff;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_DATA} tpb_tx_state_t;
endpackage

// File: testbench/tpb_supply_model.sv
`timescale 1ns/1ps
module tpb_supply_model #(
	parameter int SUPPLY_MV = 3000
) (
	input  logic       regulator_enable_input,
	input  logic       battery_monitor_enable_bit,
	input  logic [4:0] battery_threshold_code,
	output logic       battery_compare_in
);
	// Scaled by 27 to keep the toggle point in integers
	// Idle comparator rests high, so the block itself must gate it by the enable
	always_comb
	begin
		battery_compare_in = regulator_enable_input && (!battery_monitor_enable_bit
			|| SUPPLY_MV * 27 > 1250 * (72 - int'(battery_threshold_code)));
	end
endmodule

// File: testbench/tx_power_test_and_battery_monitor_register_ctrl_bench.sv
`timescale 1ns/1ps
module tx_power_test_and_battery_monitor_register_ctrl_bench;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
	logic        regulator_enable_input, battery_compare_in, battery_monitor_enable_bit, oscillator_bypass_bit;
	logic        oscillator_enable, trx_supply_switch_output, dac_override, tx_byte_valid;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, tx_byte;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [4:0]  power_amp_level_field, battery_threshold_code;
	logic [15:0] dac_static_value;
	int          errors, n_tests;
	int          cyc = 0;

	tpb_ctrl #(.BUF_DEPTH(128)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .regulator_enable_input, .battery_compare_in, .irq, .power_amp_level_field,
		.battery_monitor_enable_bit, .battery_threshold_code, .oscillator_bypass_bit, .oscillator_enable,
		.trx_supply_switch_output, .dac_override, .dac_static_value, .tx_byte, .tx_byte_valid);

	tpb_supply_model #(.SUPPLY_MV(3000)) SUP (.regulator_enable_input, .battery_monitor_enable_bit,
		.battery_threshold_code, .battery_compare_in);

	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic complete_run;
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Run is about 25000 cycles
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			errors++;
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic get_byte(input logic [7:0] exp);
		do @(posedge aclk); while (!tx_byte_valid);
		chk(tx_byte, exp);
	endtask

	task automatic t_power;
		logic [15:0] w [8] = '{16'ha0ff, 16'ha0fb, 16'ha0f7, 16'ha0f3, 16'ha0ef, 16'ha0eb, 16'ha0e7, 16'ha0e3};
		foreach (w[i])
		begin
			axw(tpb_pkg::OFF_TX_CFG, {16'h0000, w[i]});
			axr(tpb_pkg::OFF_TX_CFG);
			chk(rd, {16'h0000, w[i]});
			chk(power_amp_level_field, w[i][4:0]);
		end
		axr(8'h3c);
		chk(rs, tpb_pkg::RESP_SLVERR);
		chk(rd, 32'h0);
		axw(8'h3c, 32'h1);
		chk(rs, tpb_pkg::RESP_SLVERR);
		axw(tpb_pkg::OFF_MAIN, 32'h1);
		chk(rs, tpb_pkg::RESP_OKAY);
		// Bypass output is a flop behind the register, so it lags the response
		repeat (2) @(posedge aclk);
		chk(oscillator_bypass_bit, 1'b1);
	endtask

	task automatic t_batt;
		axw(tpb_pkg::OFF_IRQ_MASK, 32'h0);
		axw(tpb_pkg::OFF_BATT_CFG, 32'h28);
		repeat (50) @(posedge aclk);
		chk(battery_monitor_enable_bit, 1'b1);
		chk(battery_threshold_code, 5'h08);
		axr(tpb_pkg::OFF_BATT_CFG);
		chk(rd, 32'h68);
		axw(tpb_pkg::OFF_BATT_CFG, 32'h27);
		repeat (50) @(posedge aclk);
		axr(tpb_pkg::OFF_BATT_CFG);
		chk(rd, 32'h27);
		chk(irq, 1'b0);
		axr(tpb_pkg::OFF_IRQ_STATUS);
		chk(rd[0], 1'b1);
		axw(tpb_pkg::OFF_IRQ_MASK, 32'h1);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b1);
		axw(tpb_pkg::OFF_BATT_CFG, 32'h28);
		repeat (50) @(posedge aclk);
		axw(tpb_pkg::OFF_IRQ_STATUS, 32'h1);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b0);
		// Comparator rests high when disabled, so a set bit means the enable is ignored
		axw(tpb_pkg::OFF_BATT_CFG, 32'h08);
		repeat (50) @(posedge aclk);
		axr(tpb_pkg::OFF_BATT_CFG);
		chk(rd, 32'h08);
	endtask

	task automatic t_prbs;
		logic [7:0] e [7] = '{8'h00, 8'h78, 8'hb8, 8'h4b, 8'h99, 8'hc3, 8'he9};
		axw(tpb_pkg::OFF_STROBE, 32'h1);
		repeat (3) @(posedge aclk);
		chk(oscillator_enable, 1'b1);
		axw(tpb_pkg::OFF_MODEM_CFG, 32'hc);
		axw(tpb_pkg::OFF_STROBE, 32'h2);
		repeat (3) @(posedge aclk);
		chk(trx_supply_switch_output, 1'b1);
		chk(dac_override, 1'b0);
		repeat (tpb_pkg::PREAMBLE_BYTES) get_byte(tpb_pkg::PREAMBLE_BYTE);
		get_byte(tpb_pkg::SFD_BYTE);
		foreach (e[i]) get_byte(e[i]);
		axw(tpb_pkg::OFF_STROBE, 32'h4);
		repeat (3) @(posedge aclk);
		chk(trx_supply_switch_output, 1'b0);
	endtask

	task automatic t_loop;
		for (int i = 0; i < 128; i++) axw(tpb_pkg::OFF_TXBUF, 32'(i ^ 8'h5a));
		axw(tpb_pkg::OFF_MODEM_CFG, 32'h8);
		axw(tpb_pkg::OFF_DAC_TEST, 32'h1800);
		axw(tpb_pkg::OFF_STROBE, 32'h2);
		repeat (3) @(posedge aclk);
		chk(dac_override, 1'b1);
		chk(dac_static_value, 16'h1800);
		repeat (tpb_pkg::PREAMBLE_BYTES) get_byte(tpb_pkg::PREAMBLE_BYTE);
		get_byte(tpb_pkg::SFD_BYTE);
		for (int i = 0; i < 3; i++) get_byte(8'(i ^ 8'h5a));
		axw(tpb_pkg::OFF_STROBE, 32'h4);
	endtask

	// Mid-run reset, then regulator off: writes must not land until it is back
	task automatic t_regoff;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		regulator_enable_input <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		axw(tpb_pkg::OFF_TX_CFG, 32'ha0e3);
		chk(rs, tpb_pkg::RESP_OKAY);
		axr(tpb_pkg::OFF_TX_CFG);
		chk(rd, {16'h0000, tpb_pkg::TX_CFG_RESET});
		regulator_enable_input <= 1'b1;
		repeat (4) @(posedge aclk);
		axw(tpb_pkg::OFF_TX_CFG, 32'ha0e3);
		repeat (2) @(posedge aclk);
		chk(power_amp_level_field, 5'h03);
	endtask

	// Normal mode: one byte, then underflow ends the frame
	task automatic t_normal;
		axw(tpb_pkg::OFF_STROBE, 32'h1);
		axw(tpb_pkg::OFF_TXBUF, 32'h3c);
		axw(tpb_pkg::OFF_STROBE, 32'h2);
		repeat (tpb_pkg::PREAMBLE_BYTES) get_byte(tpb_pkg::PREAMBLE_BYTE);
		get_byte(tpb_pkg::SFD_BYTE);
		get_byte(8'h3c);
		repeat (900) @(posedge aclk);
		chk(trx_supply_switch_output, 1'b0);
		axr(tpb_pkg::OFF_IRQ_STATUS);
		chk(rd, 32'h6);
	endtask

	initial
	begin
		errors = 0;
		n_tests = 0;
		aresetn = 1'b0;
		regulator_enable_input = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (5) @(posedge aclk);
		chk(power_amp_level_field, 5'h1f);
		axr(tpb_pkg::OFF_TX_CFG);
		chk(rd, {16'h0000, tpb_pkg::TX_CFG_RESET});
		t_power();
		repeat (2500) @(posedge aclk);
		t_batt();
		t_prbs();
		t_loop();
		t_regoff();
		t_normal();
		complete_run();
	end
endmodule
